//--- src/ardv_pkg.sv
package ardv_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA     = 4'h0;
  localparam logic [3:0] IDX_FEATURE  = 4'h1;
  localparam logic [3:0] IDX_SEC_CNT  = 4'h2;
  localparam logic [3:0] IDX_SEC_IDX  = 4'h3;
  localparam logic [3:0] IDX_TRK_LO   = 4'h4;
  localparam logic [3:0] IDX_TRK_HI   = 4'h5;
  localparam logic [3:0] IDX_DRV_HEAD = 4'h6;
  localparam logic [3:0] IDX_OPCODE   = 4'h7;
  localparam logic [3:0] IDX_STATUS   = 4'h8;
  localparam logic [3:0] IDX_ERROR    = 4'h9;

  // opcodes
  localparam logic [7:0] OP_READ_A   = 8'h20;
  localparam logic [7:0] OP_READ_B   = 8'h21;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [7:0] OP_SENSE    = 8'h03;

  // extended error codes
  localparam logic [7:0] EXT_NONE      = 8'h00;
  localparam logic [7:0] EXT_SELF_OK   = 8'h01;
  localparam logic [7:0] EXT_MISC      = 8'h09;
  localparam logic [7:0] EXT_BAD_OP    = 8'h20;
  localparam logic [7:0] EXT_BAD_ADDR  = 8'h21;
  localparam logic [7:0] EXT_ADDR_OVF  = 8'h2f;
  localparam logic [7:0] EXT_ECC_HARD  = 8'h11;
  localparam logic [7:0] EXT_ECC_FIXED = 8'h18;
  localparam logic [7:0] EXT_ABORTED   = 8'h1f;

  // status bit positions and error flag
  localparam int         ST_BUSY   = 7;
  localparam int         ST_DRQ    = 3;
  localparam int         ST_IRQ    = 1;
  localparam int         ST_ERR    = 0;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  // sector geometry and reset values
  localparam logic [6:0] LAST_WORD  = 7'h7f;
  localparam logic [8:0] COUNT_256  = 9'h100;
  localparam logic [8:0] COUNT_ONE  = 9'h001;
  localparam logic [7:0] TF_RESET   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLV   = 2'b10;

  typedef enum logic [1:0] {
    ARDV_IDLE  = 2'b00,
    ARDV_FETCH = 2'b01,
    ARDV_XFER  = 2'b11
  } ardv_state_t;

  // address handed to the media engine
  typedef struct packed {
    logic        lba_mode;
    logic [27:0] lba;
    logic [15:0] track;
    logic [3:0]  head;
    logic [7:0]  sector;
  } ardv_media_addr_t;
endpackage : ardv_pkg

//--- src/ardv_cmd_core.sv
`timescale 1ns/1ps
// Behaviour
// - opcode 20h or 21h reads sector count sectors; zero means 256
// - read starts at sector index, track and head or linear address fields
// - per sector: busy, fill buffer, DRQ, release busy, interrupt, in order
// - good read leaves address registers on last delivered sector
// - read error stops at failing sector, keeps its address and data
// - verify 40h or 41h acts as read but never sets DRQ
// - verify sets busy, then one interrupt once all sectors checked
// - good verify leaves address registers on last checked sector
// - verify error loads failing address and count of sectors left, failing one included
// - any opcode 1Xh is a no-operation recalibrate
// - request sense puts previous extended error code in error register
// - codes 00h no error, 01h self test ok, 09h miscellaneous
// - codes 20h bad opcode, 21h bad head or sector, 2Fh overflow
// - codes 11h, 18h ECC, 10h or 14h not found, 1Fh aborted
// - self test failures use 05h, 30h-34h, 37h or 3Eh
// - voltage out of tolerance uses 35h or 36h
// - 03h write fail, 3Ah spares, 22h power level, media format codes
// - linear address bits split over head, track high, track low, sector
module ardv_cmd_core #(
  parameter int         ADDR_W     = 6,
  parameter logic [7:0] TRACK_SECS = 8'd32,
  parameter logic [3:0] HEAD_LAST  = 4'd15,
  parameter logic [15:0] TRACKS    = 16'd1024,
  parameter logic [27:0] LBA_LIMIT = 28'h0080000
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // media engine
  output logic                          media_req,
  output ardv_pkg::ardv_media_addr_t    media_addr,
  input  wire logic                     media_wvalid,
  input  wire logic [31:0]              media_wdata,
  input  wire logic                     media_done,
  input  wire logic [7:0]               media_code,
  // host interrupt line
  output logic                          intrq
);
  ardv_pkg::ardv_state_t state;
  logic [7:0]  feature_param, sector_count, start_sector_index, track_addr_low, track_addr_high, drive_head_select;
  logic [7:0]  error_reg, last_code, chk_code, opcode;
  logic        busy, drq, err, op_verify, irq_evt, aw_held, w_held;
  logic [8:0]  remaining;
  logic [6:0]  wr_ptr, rd_ptr;
  logic [31:0] w_data, sector_buf [0:127];
  logic [3:0]  aw_idx, ar_idx, w_strb;
  logic        wr_fire, rd_take, cmd_go, drain_done, adv, ver_fail, last_sec, is_read, is_ver;
  logic [27:0] lba;

  // write address and data are caught apart, answered together
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ardv_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx > ardv_pkg::IDX_ERROR) ? ardv_pkg::RESP_SLV : ardv_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // decode of a command write; only taken while idle
  assign opcode  = w_data[7:0];
  assign cmd_go  = wr_fire && aw_idx == ardv_pkg::IDX_OPCODE && w_strb[0] && state == ardv_pkg::ARDV_IDLE;
  assign is_read = opcode == ardv_pkg::OP_READ_A || opcode == ardv_pkg::OP_READ_B;
  assign is_ver  = opcode == ardv_pkg::OP_VERIFY_A || opcode == ardv_pkg::OP_VERIFY_B;
  assign lba     = {drive_head_select[3:0], track_addr_high, track_addr_low, start_sector_index};

  // range check of the start address before any media access
  always_comb begin
    chk_code = ardv_pkg::EXT_NONE;
    if (drive_head_select[6]) begin
      if (lba >= LBA_LIMIT) chk_code = ardv_pkg::EXT_ADDR_OVF;
    end else if (start_sector_index == 8'h00 || start_sector_index > TRACK_SECS ||
                 drive_head_select[3:0] > HEAD_LAST || {track_addr_high, track_addr_low} >= TRACKS) begin
      chk_code = ardv_pkg::EXT_BAD_ADDR;
    end
  end

  // media address straight from the task file flops
  assign media_addr = '{lba_mode: drive_head_select[6], lba: lba,
                        track: {track_addr_high, track_addr_low},
                        head: drive_head_select[3:0], sector: start_sector_index};

  assign last_sec   = remaining == ardv_pkg::COUNT_ONE;
  assign drain_done = rd_take && ar_idx == ardv_pkg::IDX_DATA && drq && rd_ptr == ardv_pkg::LAST_WORD;
  assign adv        = (state == ardv_pkg::ARDV_FETCH && media_done && media_code == ardv_pkg::EXT_NONE &&
                       op_verify && !last_sec) ||
                      (state == ardv_pkg::ARDV_XFER && drain_done && !err && !last_sec);
  assign ver_fail   = state == ardv_pkg::ARDV_FETCH && media_done && media_code != ardv_pkg::EXT_NONE && op_verify;

  // task file; host writes only while idle, the engine steps the address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      feature_param      <= ardv_pkg::TF_RESET;
      sector_count       <= ardv_pkg::TF_RESET;
      start_sector_index <= ardv_pkg::TF_RESET;
      track_addr_low     <= ardv_pkg::TF_RESET;
      track_addr_high    <= ardv_pkg::TF_RESET;
      drive_head_select  <= ardv_pkg::TF_RESET;
    end else if (adv) begin
      // address moves only when another sector follows, so it ends on the last one
      if (drive_head_select[6]) begin
        {drive_head_select[3:0], track_addr_high, track_addr_low, start_sector_index} <= lba + 28'h1;
      end else if (start_sector_index == TRACK_SECS) begin
        start_sector_index <= 8'h01;
        if (drive_head_select[3:0] == HEAD_LAST) begin
          drive_head_select[3:0]            <= 4'h0;
          {track_addr_high, track_addr_low} <= {track_addr_high, track_addr_low} + 16'h1;
        end else begin
          drive_head_select[3:0] <= drive_head_select[3:0] + 4'h1;
        end
      end else begin
        start_sector_index <= start_sector_index + 8'h01;
      end
    end else if (ver_fail) begin
      sector_count <= remaining[7:0];
    end else if (wr_fire && w_strb[0] && state == ardv_pkg::ARDV_IDLE) begin
      case (aw_idx)
        ardv_pkg::IDX_FEATURE:  feature_param      <= w_data[7:0];
        ardv_pkg::IDX_SEC_CNT:  sector_count       <= w_data[7:0];
        ardv_pkg::IDX_SEC_IDX:  start_sector_index <= w_data[7:0];
        ardv_pkg::IDX_TRK_LO:   track_addr_low     <= w_data[7:0];
        ardv_pkg::IDX_TRK_HI:   track_addr_high    <= w_data[7:0];
        ardv_pkg::IDX_DRV_HEAD: drive_head_select  <= w_data[7:0];
        default: ;
      endcase
    end
  end

  // command sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ardv_pkg::ARDV_IDLE;
      busy      <= 1'b0;
      drq       <= 1'b0;
      err       <= 1'b0;
      op_verify <= 1'b0;
      remaining <= 9'h000;
      media_req <= 1'b0;
      irq_evt   <= 1'b0;
      last_code <= ardv_pkg::EXT_NONE;
      error_reg <= ardv_pkg::TF_RESET;
    end else begin
      media_req <= 1'b0;
      irq_evt   <= 1'b0;
      case (state)
        ardv_pkg::ARDV_IDLE: begin
          if (cmd_go) begin
            err       <= 1'b0;
            error_reg <= ardv_pkg::TF_RESET;
            if ((is_read || is_ver) && chk_code != ardv_pkg::EXT_NONE) begin
              err       <= 1'b1;
              error_reg <= ardv_pkg::ERR_ABORT;
              last_code <= chk_code;
              irq_evt   <= 1'b1;
            end else if (is_read || is_ver) begin
              busy      <= 1'b1;
              op_verify <= is_ver;
              remaining <= (sector_count == 8'h00) ? ardv_pkg::COUNT_256 : {1'b0, sector_count};
              media_req <= 1'b1;
              state     <= ardv_pkg::ARDV_FETCH;
            end else if (opcode[7:4] == ardv_pkg::OP_RECAL_HI) begin
              last_code <= ardv_pkg::EXT_NONE;
              irq_evt   <= 1'b1;
            end else if (opcode == ardv_pkg::OP_SENSE) begin
              error_reg <= last_code;
              last_code <= ardv_pkg::EXT_NONE;
              irq_evt   <= 1'b1;
            end else begin
              err       <= 1'b1;
              error_reg <= ardv_pkg::ERR_ABORT;
              last_code <= ardv_pkg::EXT_BAD_OP;
              irq_evt   <= 1'b1;
            end
          end
        end
        ardv_pkg::ARDV_FETCH: begin
          if (media_done) begin
            if (media_code != ardv_pkg::EXT_NONE) begin
              // media engine reports its own code unchanged
              err       <= 1'b1;
              error_reg <= ardv_pkg::ERR_ABORT;
              last_code <= media_code;
            end
            if (op_verify) begin
              if (media_code != ardv_pkg::EXT_NONE || last_sec) begin
                busy    <= 1'b0;
                irq_evt <= 1'b1;
                state   <= ardv_pkg::ARDV_IDLE;
                if (media_code == ardv_pkg::EXT_NONE) last_code <= ardv_pkg::EXT_NONE;
              end else begin
                remaining <= remaining - 9'h001;
                media_req <= 1'b1;
              end
            end else begin
              drq   <= 1'b1;
              state <= ardv_pkg::ARDV_XFER;
            end
          end
        end
        ardv_pkg::ARDV_XFER: begin
          if (busy) begin
            busy    <= 1'b0;
            irq_evt <= 1'b1;
          end
          if (drain_done) begin
            drq <= 1'b0;
            if (err || last_sec) begin
              state <= ardv_pkg::ARDV_IDLE;
              if (!err) last_code <= ardv_pkg::EXT_NONE;
            end else begin
              busy      <= 1'b1;
              remaining <= remaining - 9'h001;
              media_req <= 1'b1;
              state     <= ardv_pkg::ARDV_FETCH;
            end
          end
        end
        default: state <= ardv_pkg::ARDV_IDLE;
      endcase
    end
  end

  // interrupt line; a status read clears it, a new event wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intrq <= 1'b0;
    end else if (irq_evt) begin
      intrq <= 1'b1;
    end else if (rd_take && ar_idx == ardv_pkg::IDX_STATUS) begin
      intrq <= 1'b0;
    end
  end

  // sector buffer fill; the failing sector stays in place for the host
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 7'h00;
    end else if (media_req) begin
      wr_ptr <= 7'h00;
    end else if (media_wvalid) begin
      wr_ptr <= wr_ptr + 7'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (media_wvalid && !media_req) sector_buf[wr_ptr] <= media_wdata;
  end

  // register reads; data reads pop the buffer only while DRQ stands
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[5:2];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ardv_pkg::RESP_OKAY;
      rd_ptr       <= 7'h00;
    end else begin
      if (state == ardv_pkg::ARDV_FETCH && media_done) rd_ptr <= 7'h00;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ardv_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (ar_idx)
          ardv_pkg::IDX_DATA: begin
            if (drq) begin
              s_axi_rdata <= sector_buf[rd_ptr];
              rd_ptr      <= rd_ptr + 7'h01;
            end
          end
          ardv_pkg::IDX_FEATURE:  s_axi_rdata[7:0] <= feature_param;
          ardv_pkg::IDX_SEC_CNT:  s_axi_rdata[7:0] <= sector_count;
          ardv_pkg::IDX_SEC_IDX:  s_axi_rdata[7:0] <= start_sector_index;
          ardv_pkg::IDX_TRK_LO:   s_axi_rdata[7:0] <= track_addr_low;
          ardv_pkg::IDX_TRK_HI:   s_axi_rdata[7:0] <= track_addr_high;
          ardv_pkg::IDX_DRV_HEAD: s_axi_rdata[7:0] <= drive_head_select;
          ardv_pkg::IDX_OPCODE:   s_axi_rdata[7:0] <= 8'h00;
          ardv_pkg::IDX_STATUS: begin
            s_axi_rdata[ardv_pkg::ST_BUSY] <= busy;
            s_axi_rdata[ardv_pkg::ST_DRQ]  <= drq;
            s_axi_rdata[ardv_pkg::ST_IRQ]  <= intrq;
            s_axi_rdata[ardv_pkg::ST_ERR]  <= err;
          end
          ardv_pkg::IDX_ERROR:    s_axi_rdata[7:0] <= error_reg;
          default:                s_axi_rresp <= ardv_pkg::RESP_SLV;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  a_verify_no_drq: assert property (@(posedge clk) disable iff (!rstn)
    op_verify && state != ardv_pkg::ARDV_IDLE |-> !drq) else $error("drq during verify");
  a_drq_under_busy: assert property (@(posedge clk) disable iff (!rstn)
    $rose(drq) |-> busy ##1 !busy ##1 intrq) else $error("drq, busy, irq order wrong");
  a_count_zero: assert property (@(posedge clk) disable iff (!rstn)
    cmd_go && (is_read || is_ver) && chk_code == 8'h00 && sector_count == 8'h00 |=> remaining == 9'h100)
    else $error("count zero not 256");
  a_read_starts: assert property (@(posedge clk) disable iff (!rstn)
    cmd_go && (is_read || is_ver) && chk_code == 8'h00 |=> busy && media_req) else $error("no start");
  a_recal_quick: assert property (@(posedge clk) disable iff (!rstn)
    cmd_go && opcode[7:4] == 4'h1 |=> !busy && !err ##1 intrq) else $error("recalibrate slow");
  a_sense_code: assert property (@(posedge clk) disable iff (!rstn)
    cmd_go && opcode == 8'h03 |=> error_reg == $past(last_code)) else $error("sense code lost");
  a_bad_opcode: assert property (@(posedge clk) disable iff (!rstn)
    cmd_go && !is_read && !is_ver && opcode[7:4] != 4'h1 && opcode != 8'h03 |=> last_code == 8'h20 && err)
    else $error("bad opcode code");
  a_verify_left: assert property (@(posedge clk) disable iff (!rstn)
    ver_fail |=> sector_count == $past(remaining[7:0]) && !busy) else $error("unchecked count wrong");
  a_lba_split: assert property (@(posedge clk) disable iff (!rstn)
    adv && drive_head_select[6] |=> lba == $past(lba) + 28'h1) else $error("lba step wrong");
  a_error_holds: assert property (@(posedge clk) disable iff (!rstn)
    state == ardv_pkg::ARDV_XFER && err |-> $stable(start_sector_index) && $stable(track_addr_low))
    else $error("failing address moved");
  a_one_irq_verify: assert property (@(posedge clk) disable iff (!rstn)
    op_verify && state == ardv_pkg::ARDV_FETCH && media_done && media_code == 8'h00 && !last_sec |=> !irq_evt)
    else $error("verify irq per sector");
endmodule : ardv_cmd_core

//--- verification/ardv_media_model.sv
`timescale 1ns/1ps
// media engine stand-in: random fetch delay, 128 words, then done with a code
module ardv_media_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // fetch request
  input  wire logic                       media_req,
  input  wire ardv_pkg::ardv_media_addr_t media_addr,
  // word stream back
  output logic                            media_wvalid,
  output logic [31:0]                     media_wdata,
  output logic                            media_done,
  output logic [7:0]                      media_code,
  // fault set-up from the bench
  input  wire logic [23:0]                fail_tag,
  input  wire logic [7:0]                 fail_code
);
  logic [23:0] tag;

  // one sector in flight; idle lines are inverted so stale words never look valid
  initial begin
    media_wvalid = 1'b0;
    media_wdata  = 32'h0;
    media_done   = 1'b0;
    media_code   = 8'h00;
    forever begin
      @(posedge clk);
      if (rstn && media_req) begin
        tag = media_addr.lba_mode ? media_addr.lba[23:0] : {media_addr.track, media_addr.sector};
        repeat ($urandom_range(1, 9)) @(posedge clk);
        for (int k = 0; k < 128; k++) begin
          media_wvalid <= 1'b1;
          media_wdata  <= {tag, 1'b0, 7'(k)};
          @(posedge clk);
        end
        media_wvalid <= 1'b0;
        media_wdata  <= ~media_wdata;
        media_done   <= 1'b1;
        media_code   <= (tag == fail_tag) ? fail_code : 8'h00;
        @(posedge clk);
        media_done <= 1'b0;
        media_code <= ~media_code;
      end
    end
  end
endmodule : ardv_media_model

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  // bus, media and bookkeeping signals
  logic                       clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic                       awready, wready, bvalid, arready, rvalid, mreq, mwv, mdone, intrq;
  logic [5:0]                 awaddr, araddr;
  logic [3:0]                 wstrb;
  logic [1:0]                 bresp, rresp, rsp;
  logic [31:0]                wdata, rdata, mwd, rd;
  logic [7:0]                 mcode, fcode, h, t, s;
  logic [23:0]                ftag;
  ardv_pkg::ardv_media_addr_t maddr;
  int                         failures, checked, cyc;
  logic [7:0]                 codes [11] = '{8'h1f, 8'h05, 8'h30, 8'h34, 8'h37, 8'h3e, 8'h35, 8'h36, 8'h03, 8'h3a, 8'h22};

  ardv_cmd_core i_dut (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .media_req(mreq), .media_addr(maddr),
    .media_wvalid(mwv), .media_wdata(mwd), .media_done(mdone), .media_code(mcode), .intrq(intrq));

  ardv_media_model i_media (
    .clk(clk), .rstn(rstn), .media_req(mreq), .media_addr(maddr), .media_wvalid(mwv), .media_wdata(mwd),
    .media_done(mdone), .media_code(mcode), .fail_tag(ftag), .fail_code(fcode));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  // address and data offered together, each released when taken
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bit a, w;
    a = 0;
    w = 0;
    awaddr  <= {i, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awready === 1'b1) awvalid <= 1'b0;
      if (!w && wready === 1'b1) wvalid <= 1'b0;
      a = a | (awready === 1'b1);
      w = w | (wready === 1'b1);
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr

  task automatic rdr(input logic [3:0] i);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd  = rdata;
    rsp = rresp;
  endtask : rdr

  task automatic wait_irq();
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk8("intrq", 8'h01, {7'h0, intrq});
  endtask : wait_irq

  task automatic setup(input logic [7:0] hd, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] sc,
                       input logic [7:0] cnt);
    wr(ardv_pkg::IDX_DRV_HEAD, hd);
    wr(ardv_pkg::IDX_TRK_HI, hi);
    wr(ardv_pkg::IDX_TRK_LO, lo);
    wr(ardv_pkg::IDX_SEC_IDX, sc);
    wr(ardv_pkg::IDX_SEC_CNT, cnt);
  endtask : setup

  // early status look only where a long busy phase is certain
  task automatic cmd(input logic [7:0] op, input bit early);
    wr(ardv_pkg::IDX_OPCODE, op);
    if (early) rdr(ardv_pkg::IDX_STATUS);
    if (early) chk8("busy", 8'h80, rd[7:0] & 8'h80);
    wait_irq();
    rdr(ardv_pkg::IDX_STATUS);
  endtask : cmd

  task automatic sense(input logic [7:0] e);
    cmd(ardv_pkg::OP_SENSE, 1'b0);
    rdr(ardv_pkg::IDX_ERROR);
    chk8("ext code", e, rd[7:0]);
  endtask : sense

  task automatic drain(input logic [23:0] tg);
    for (int k = 0; k < 128; k++) begin
      rdr(ardv_pkg::IDX_DATA);
      chk32("data", {tg, 1'b0, 7'(k)}, rd);
    end
  endtask : drain

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
    ftag = 24'hffffff;
    fcode = 8'h00;
    failures = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(95));
    h = 8'($urandom_range(0, 15));
    t = 8'($urandom_range(0, 255));
    s = 8'($urandom_range(1, 28));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // two sectors, one interrupt with drq each
    setup(h, 8'h00, t, s, 8'h02);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) cmd(ardv_pkg::OP_READ_A, 1'b1);
      else wait_irq();
      if (k != 0) rdr(ardv_pkg::IDX_STATUS);
      chk8("status", 8'h08, rd[7:0] & 8'h89);
      drain({8'h00, t, s + 8'(k)});
    end
    rdr(ardv_pkg::IDX_SEC_IDX);
    chk8("sector", s + 8'd1, rd[7:0]);
    end_test("read");
    // failing read keeps flawed data and failing address
    ftag = {8'h00, t, s};
    fcode = ardv_pkg::EXT_ECC_HARD;
    setup(h, 8'h00, t, s, 8'h03);
    cmd(ardv_pkg::OP_READ_B, 1'b1);
    chk8("status", 8'h09, rd[7:0] & 8'h89);
    drain({8'h00, t, s});
    rdr(ardv_pkg::IDX_SEC_IDX);
    chk8("sector", s, rd[7:0]);
    sense(ardv_pkg::EXT_ECC_HARD);
    sense(ardv_pkg::EXT_NONE);
    end_test("read error");
    // verify: good run, then failure on the second sector
    ftag = 24'hffffff;
    setup(h, 8'h00, t, s, 8'h03);
    cmd(ardv_pkg::OP_VERIFY_A, 1'b1);
    chk8("status", 8'h00, rd[7:0] & 8'h89);
    rdr(ardv_pkg::IDX_DATA);
    chk32("no data", 32'h0, rd);
    rdr(ardv_pkg::IDX_SEC_IDX);
    chk8("sector", s + 8'd2, rd[7:0]);
    ftag = {8'h00, t, s + 8'd1};
    fcode = ardv_pkg::EXT_ECC_FIXED;
    setup(h, 8'h00, t, s, 8'h00);
    cmd(ardv_pkg::OP_VERIFY_B, 1'b1);
    repeat (20) @(posedge clk);
    chk8("intrq", 8'h00, {7'h0, intrq});
    chk8("status", 8'h01, rd[7:0] & 8'h89);
    rdr(ardv_pkg::IDX_SEC_IDX);
    chk8("sector", s + 8'd1, rd[7:0]);
    rdr(ardv_pkg::IDX_SEC_CNT);
    chk8("count", 8'hff, rd[7:0]);
    sense(ardv_pkg::EXT_ECC_FIXED);
    // media codes reach the sense result unchanged
    ftag = {8'h00, t, s};
    foreach (codes[i]) begin
      fcode = codes[i];
      setup(h, 8'h00, t, s, 8'h01);
      cmd(ardv_pkg::OP_VERIFY_A, 1'b1);
      sense(codes[i]);
    end
    end_test("verify");
    for (int n = 0; n < 16; n++) begin
      cmd({ardv_pkg::OP_RECAL_HI, 4'(n)}, 1'b0);
      chk8("status", 8'h00, rd[7:0] & 8'h89);
    end
    end_test("recal");
    // refused commands and addresses, then a good linear read
    cmd(8'h55, 1'b0);
    chk8("status", 8'h01, rd[7:0] & 8'h89);
    rdr(ardv_pkg::IDX_ERROR);
    chk8("error", ardv_pkg::ERR_ABORT, rd[7:0]);
    sense(ardv_pkg::EXT_BAD_OP);
    setup(h, 8'h00, t, 8'h00, 8'h01);
    cmd(ardv_pkg::OP_READ_A, 1'b0);
    sense(ardv_pkg::EXT_BAD_ADDR);
    setup(8'h40, 8'h08, 8'h00, 8'h00, 8'h01);
    cmd(ardv_pkg::OP_READ_A, 1'b0);
    sense(ardv_pkg::EXT_ADDR_OVF);
    ftag = 24'hffffff;
    setup(8'h40, 8'h07, t, s, 8'h02);
    cmd(ardv_pkg::OP_READ_A, 1'b1);
    drain({8'h07, t, s});
    wait_irq();
    drain({8'h07, t, s + 8'd1});
    end_test("errors");
    rdr(4'hc);
    chk8("rresp", {6'h0, ardv_pkg::RESP_SLV}, {6'h0, rsp});
    wr(4'hd, 8'h12);
    chk8("bresp", {6'h0, ardv_pkg::RESP_SLV}, {6'h0, rsp});
    wr(ardv_pkg::IDX_FEATURE, t);
    rdr(ardv_pkg::IDX_FEATURE);
    chk8("feature", t, rd[7:0]);
    rdr(ardv_pkg::IDX_OPCODE);
    chk8("opcode", 8'h00, rd[7:0]);
    end_test("map");
    give_verdict();
  end
endmodule : testbench
